// ===== ars_consts.svh
`ifndef ARS_CONSTS_SVH
`define ARS_CONSTS_SVH

`define ARS_ADDR_RES_LOW   8'h78
`define ARS_ADDR_RES_HIGH  8'h79
`define ARS_ADDR_CTRL_A    8'h7A
`define ARS_ADDR_INSEL     8'h7C
`define ARS_ADDR_STATUS    8'h70
`define ARS_ADDR_MASK      8'h71

`define ARS_INSEL_RESET    8'h00
`define ARS_CTRL_EN_BIT    7
`define ARS_CTRL_BUSY_BIT  6
`define ARS_CTRL_DONE_BIT  4
`define ARS_LEFT_BIT       5
`define ARS_REF_HI         7
`define ARS_REF_LO         6

`define ARS_EV_DONE        0
`define ARS_EV_ABORT       1
`define ARS_EV_LOST        2
`define ARS_EV_RESET       3'h0

`define ARS_REF_INTERNAL   2'h3
`define ARS_REF_SUPPLY     2'h1
`define ARS_REF_RESERVED   2'h2
`define ARS_CH_BANDGAP     5'h1E
`define ARS_CH_GROUND      5'h1F
`define ARS_CH_DIFF2_LAST  5'h1D

`define ARS_SE_MAX         12'sh3FF
`define ARS_DIFF_MAX       12'sh1FF
`define ARS_DIFF_MIN       -12'sh200

`endif

// ===== ars_pkg.sv
package ars_pkg;

    typedef enum logic [1:0] {
        ARS_IDLE = 2'b01,
        ARS_BUSY = 2'b10
    } ars_state_t;

    typedef struct packed {
        logic       valid;
        logic       diff;
        logic [2:0] pos;
        logic [2:0] neg;
        logic       bandgap;
        logic       ground;
    } ars_chan_t;

    typedef struct packed {
        ars_chan_t  chan;
        logic [1:0] ref_sel;
        logic       ref_int_on;
        logic       enable;
        logic       start;
        logic       abort;
    } ars_ana_t;

    typedef struct packed {
        ars_state_t st;
        logic [7:0] insel;
        logic [7:0] act_sel;
        logic       en;
        logic [9:0] result;
        logic       lock;
        logic [2:0] status;
        logic [2:0] mask;
        logic [7:0] rdata;
        logic       irq;
        ars_ana_t   ana;
    } ars_regs_t;

endpackage : ars_pkg

// ===== ars_ctrl.sv
`timescale 1ns/1ps
`include "ars_consts.svh"
// Functional notes
// - after completion, the conversion code is readable from the two result bytes
// - single-ended: unsigned code vin*1024/vref, 0x000 ground, 0x3FF top step
// - differential: signed code diff*512/vref, clamped to 0x200..0x1FF
// - reference field 7:6: 00 external pin, 01 supply, 10 reserved, 11 internal 1.1V
// - reference and channel writes during a conversion apply only after it ends
// - left-justify bit 5 set gives left adjusted result, else right adjusted
// - left-justify change reformats result reads at once, even mid-conversion
// - channel 0-7 single-ended, 11110 bandgap, 11111 ground, 01xxx unassigned
// - 10xxx positive 0-7 against input 1; 11000-11101 positive 0-5 against input 2
// - enable bit 7 of control A switches converter on or off
// - clearing enable during a conversion aborts it without completion
// - right: 7:0 low, 9:8 high low bits; left: 9:2 high, 1:0 low top bits
// - completion flag sets whenever a conversion finishes, also when the lock keeps the old result
// - low byte read blocks result updates until the high byte is read
module ars_ctrl (
    input  wire logic        ref_clk,
    input  wire logic        reset,
    input  wire logic [7:0]  bus_addr,
    input  wire logic [7:0]  bus_wdata,
    input  wire logic        bus_we,
    input  wire logic        bus_re,
    output logic      [7:0]  bus_rdata,
    input  wire logic        conv_start,
    input  wire logic        core_done,
    input  wire logic [11:0] core_code,
    output ars_pkg::ars_ana_t ana_ctl,
    output logic             conv_busy,
    output logic             irq
);

    ars_pkg::ars_regs_t r_r;
    ars_pkg::ars_regs_t r_nxt;

    function automatic ars_pkg::ars_chan_t decode_chan(input logic [4:0] mux);
        ars_pkg::ars_chan_t c;
        c = '0;
        c.valid = 1'b1;
        c.pos = mux[2:0];
        case (mux[4:3])
            2'b00: c.diff = 1'b0;
            2'b01: c.valid = 1'b0;
            2'b10: begin
                c.diff = 1'b1;
                c.neg = 3'h1;
            end
            default: begin
                if (mux <= `ARS_CH_DIFF2_LAST) begin
                    c.diff = 1'b1;
                    c.neg = 3'h2;
                end else begin
                    c.pos = 3'h0;
                    c.bandgap = (mux == `ARS_CH_BANDGAP);
                    c.ground = (mux == `ARS_CH_GROUND);
                end
            end
        endcase
        return c;
    endfunction : decode_chan

    // both bytes come from one 16-bit image rebuilt each cycle; the low byte read lock keeps the result until the high read
    function automatic logic [15:0] fmt_result(input logic [9:0] code, input logic left);
        if (left)
            return {code, 6'h00};
        else
            return {6'h00, code};
    endfunction : fmt_result

    function automatic logic [9:0] clamp_code(input logic signed [11:0] raw, input logic diff);
        logic [9:0] v;
        v = raw[9:0];
        if (diff) begin
            if (raw > `ARS_DIFF_MAX)
                v = 10'h1FF;
            else if (raw < `ARS_DIFF_MIN)
                v = 10'h200;
        end else begin
            if (raw < 12'sh000)
                v = 10'h000;
            else if (raw > `ARS_SE_MAX)
                v = 10'h3FF;
        end
        return v;
    endfunction : clamp_code

    logic        wr_ctrl;
    logic        wr_insel;
    logic        rd_low;
    logic        rd_high;
    logic        finish;
    logic        abort_now;
    logic [2:0]  ev_set;
    logic [2:0]  ev_clr;
    logic [15:0] img;

    always_comb begin
        wr_ctrl   = bus_we && (bus_addr == `ARS_ADDR_CTRL_A);
        wr_insel  = bus_we && (bus_addr == `ARS_ADDR_INSEL);
        rd_low    = bus_re && (bus_addr == `ARS_ADDR_RES_LOW);
        rd_high   = bus_re && (bus_addr == `ARS_ADDR_RES_HIGH);
        abort_now = (r_r.st == ars_pkg::ARS_BUSY) && wr_ctrl
                    && !bus_wdata[`ARS_CTRL_EN_BIT];
        finish    = (r_r.st == ars_pkg::ARS_BUSY) && core_done && !abort_now;
        img       = fmt_result(r_r.result, r_r.insel[`ARS_LEFT_BIT]);
        ev_set    = '0;
        ev_set[`ARS_EV_DONE]  = finish;
        ev_set[`ARS_EV_ABORT] = abort_now;
        ev_set[`ARS_EV_LOST]  = finish && r_r.lock;
        ev_clr    = '0;
        if (bus_we && bus_addr == `ARS_ADDR_STATUS)
            ev_clr = bus_wdata[2:0];
        if (wr_ctrl && bus_wdata[`ARS_CTRL_DONE_BIT])
            ev_clr[`ARS_EV_DONE] = 1'b1;

        r_nxt = r_r;
        r_nxt.ana.start = 1'b0;
        r_nxt.ana.abort = 1'b0;

        if (wr_insel)
            r_nxt.insel = bus_wdata;
        if (wr_ctrl)
            r_nxt.en = bus_wdata[`ARS_CTRL_EN_BIT];
        if (bus_we && bus_addr == `ARS_ADDR_MASK)
            r_nxt.mask = bus_wdata[2:0];

        case (r_r.st)
            ars_pkg::ARS_IDLE: begin
                r_nxt.act_sel = r_nxt.insel;
                if (conv_start && r_nxt.en) begin
                    r_nxt.st = ars_pkg::ARS_BUSY;
                    r_nxt.ana.start = 1'b1;
                end
            end
            ars_pkg::ARS_BUSY: begin
                // channel and reference settings frozen until this conversion finishes or aborts
                if (abort_now) begin
                    r_nxt.st = ars_pkg::ARS_IDLE;
                    r_nxt.ana.abort = 1'b1;
                end else if (finish) begin
                    r_nxt.st = ars_pkg::ARS_IDLE;
                    if (!r_r.lock)
                        r_nxt.result = clamp_code(core_code, r_r.ana.chan.diff);
                end
            end
            default: r_nxt.st = ars_pkg::ARS_IDLE;
        endcase

        // set wins over a clear arriving in the same cycle
        r_nxt.status = (r_r.status & ~ev_clr) | ev_set;
        r_nxt.irq    = |(r_nxt.status & r_nxt.mask);

        if (rd_low)
            r_nxt.lock = 1'b1;
        if (rd_high)
            r_nxt.lock = 1'b0;

        r_nxt.rdata = 8'h00;
        if (bus_re) begin
            case (bus_addr)
                `ARS_ADDR_RES_LOW:  r_nxt.rdata = img[7:0];
                `ARS_ADDR_RES_HIGH: r_nxt.rdata = img[15:8];
                `ARS_ADDR_INSEL:    r_nxt.rdata = r_r.insel;
                `ARS_ADDR_CTRL_A:   r_nxt.rdata = {r_r.en, (r_r.st == ars_pkg::ARS_BUSY), 1'b0,
                                                   r_r.status[`ARS_EV_DONE], 4'h0};
                `ARS_ADDR_STATUS:   r_nxt.rdata = {5'h00, r_r.status};
                `ARS_ADDR_MASK:     r_nxt.rdata = {5'h00, r_r.mask};
                default:            r_nxt.rdata = 8'h00;
            endcase
        end

        r_nxt.ana.chan       = decode_chan(r_nxt.act_sel[4:0]);
        r_nxt.ana.ref_sel    = r_nxt.act_sel[`ARS_REF_HI:`ARS_REF_LO];
        r_nxt.ana.ref_int_on = (r_nxt.ana.ref_sel == `ARS_REF_INTERNAL);
        r_nxt.ana.enable     = r_nxt.en;
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            r_r       <= '0;
            r_r.st    <= ars_pkg::ARS_IDLE;
            r_r.insel <= `ARS_INSEL_RESET;
            r_r.status <= `ARS_EV_RESET;
            r_r.ana.chan.valid <= 1'b1;
        end else begin
            r_r <= r_nxt;
        end
    end

    assign bus_rdata = r_r.rdata;
    assign ana_ctl   = r_r.ana;
    // one-hot code: bit 1 is the busy state, read straight from its flop
    assign conv_busy = r_r.st[1];
    assign irq       = r_r.irq;

    property p_abort;
        @(posedge ref_clk) disable iff (reset)
        abort_now |=> (r_r.st == ars_pkg::ARS_IDLE) && ana_ctl.abort && !ana_ctl.enable
                      && !$rose(r_r.status[`ARS_EV_DONE]) && $stable(r_r.result) ##1 !ana_ctl.abort;
    endproperty
    a_abort: assert property (p_abort) else $error("abort did not stop the conversion");

    property p_done;
        @(posedge ref_clk) disable iff (reset)
        (finish && !r_r.lock) |=> r_r.status[`ARS_EV_DONE] && (r_r.result == $past(r_nxt.result));
    endproperty
    a_done: assert property (p_done) else $error("done flag or result not updated");

    property p_hold_sel;
        @(posedge ref_clk) disable iff (reset)
        (r_r.st == ars_pkg::ARS_BUSY) && $past(r_r.st == ars_pkg::ARS_BUSY) |-> $stable(r_r.act_sel);
    endproperty
    a_hold_sel: assert property (p_hold_sel) else $error("settings changed mid conversion");

    property p_lock;
        @(posedge ref_clk) disable iff (reset)
        rd_low ##1 (!rd_high && r_r.lock) [*2] |-> $stable(r_r.result);
    endproperty
    a_lock: assert property (p_lock) else $error("result changed while locked");

    property p_left_low;
        @(posedge ref_clk) disable iff (reset)
        (rd_low && r_r.insel[`ARS_LEFT_BIT]) |=> (bus_rdata == {$past(r_r.result[1:0]), 6'h00});
    endproperty
    a_left_low: assert property (p_left_low) else $error("left adjusted low byte wrong");

    property p_right_high;
        @(posedge ref_clk) disable iff (reset)
        (rd_high && !r_r.insel[`ARS_LEFT_BIT]) |=> (bus_rdata == {6'h00, $past(r_r.result[9:8])});
    endproperty
    a_right_high: assert property (p_right_high) else $error("right adjusted high byte wrong");

    property p_ref;
        @(posedge ref_clk) disable iff (reset)
        ana_ctl.ref_int_on == (r_r.act_sel[7:6] == 2'b11);
    endproperty
    a_ref: assert property (p_ref) else $error("internal reference decode wrong");

    property p_chan;
        @(posedge ref_clk) disable iff (reset)
        (r_r.act_sel[4:3] == 2'b10) |-> ana_ctl.chan.diff && (ana_ctl.chan.neg == 3'h1)
                                        && (ana_ctl.chan.pos == r_r.act_sel[2:0]);
    endproperty
    a_chan: assert property (p_chan) else $error("differential pair decode wrong");

    property p_ground;
        @(posedge ref_clk) disable iff (reset)
        (r_r.act_sel[4:0] == 5'h1F) |-> ana_ctl.chan.ground && !ana_ctl.chan.diff;
    endproperty
    a_ground: assert property (p_ground) else $error("ground channel decode wrong");

    property p_clamp;
        @(posedge ref_clk) disable iff (reset)
        (finish && !r_r.lock && r_r.ana.chan.diff && $signed(core_code) > 12'sh1FF)
        |=> r_r.result == 10'h1FF;
    endproperty
    a_clamp: assert property (p_clamp) else $error("differential clamp wrong");

    property p_se;
        @(posedge ref_clk) disable iff (reset)
        (finish && !r_r.lock && !r_r.ana.chan.diff && !core_code[11])
        |=> r_r.result == (($past(core_code) > 12'h3FF) ? 10'h3FF : $past(core_code[9:0]));
    endproperty
    a_se: assert property (p_se) else $error("single-ended code wrong");

    property p_en;
        @(posedge ref_clk) disable iff (reset)
        wr_ctrl |=> ana_ctl.enable == $past(bus_wdata[7]);
    endproperty
    a_en: assert property (p_en) else $error("enable bit not applied");

    property p_irq;
        @(posedge ref_clk) disable iff (reset)
        irq == |(r_r.status & r_r.mask);
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt level wrong");

    property p_start;
        @(posedge ref_clk) disable iff (reset)
        (r_r.st == ars_pkg::ARS_IDLE) && conv_start && (wr_ctrl ? bus_wdata[`ARS_CTRL_EN_BIT] : r_r.en)
        |=> ana_ctl.start && conv_busy ##1 !ana_ctl.start;
    endproperty
    a_start: assert property (p_start) else $error("enabled start not taken");

    property p_no_start;
        @(posedge ref_clk) disable iff (reset)
        (r_r.st == ars_pkg::ARS_IDLE) && conv_start && !r_r.en && !wr_ctrl |=> !conv_busy && !ana_ctl.start;
    endproperty
    a_no_start: assert property (p_no_start) else $error("start taken while disabled");

    property p_lost;
        @(posedge ref_clk) disable iff (reset)
        (finish && r_r.lock) |=> r_r.status[`ARS_EV_LOST] && r_r.status[`ARS_EV_DONE] && $stable(r_r.result);
    endproperty
    a_lost: assert property (p_lost) else $error("locked result overwritten");

    property p_lock_set;
        @(posedge ref_clk) disable iff (reset)
        (rd_low || rd_high) |=> (r_r.lock == $past(rd_low));
    endproperty
    a_lock_set: assert property (p_lock_set) else $error("result lock not following byte reads");

    property p_left_high;
        @(posedge ref_clk) disable iff (reset)
        (rd_high && r_r.insel[`ARS_LEFT_BIT]) |=> (bus_rdata == $past(r_r.result[9:2]));
    endproperty
    a_left_high: assert property (p_left_high) else $error("left adjusted high byte wrong");

    property p_right_low;
        @(posedge ref_clk) disable iff (reset)
        (rd_low && !r_r.insel[`ARS_LEFT_BIT]) |=> (bus_rdata == $past(r_r.result[7:0]));
    endproperty
    a_right_low: assert property (p_right_low) else $error("right adjusted low byte wrong");

    property p_diff2;
        @(posedge ref_clk) disable iff (reset)
        (r_r.act_sel[4:3] == 2'h3) && (r_r.act_sel[4:0] <= `ARS_CH_DIFF2_LAST)
        |-> ana_ctl.chan.diff && (ana_ctl.chan.neg == 3'h2) && (ana_ctl.chan.pos == r_r.act_sel[2:0]);
    endproperty
    a_diff2: assert property (p_diff2) else $error("second differential group decode wrong");

    property p_single;
        @(posedge ref_clk) disable iff (reset)
        (r_r.act_sel[4:3] == 2'h0)
        |-> ana_ctl.chan.valid && !ana_ctl.chan.diff && (ana_ctl.chan.pos == r_r.act_sel[2:0]);
    endproperty
    a_single: assert property (p_single) else $error("single-ended channel decode wrong");

    property p_unassigned;
        @(posedge ref_clk) disable iff (reset)
        (r_r.act_sel[4:3] == 2'h1) |-> !ana_ctl.chan.valid && !ana_ctl.chan.diff;
    endproperty
    a_unassigned: assert property (p_unassigned) else $error("unassigned channel marked valid");

    property p_clamp_low;
        @(posedge ref_clk) disable iff (reset)
        (finish && !r_r.lock && r_r.ana.chan.diff && $signed(core_code) < `ARS_DIFF_MIN)
        |=> r_r.result == 10'h200;
    endproperty
    a_clamp_low: assert property (p_clamp_low) else $error("differential low clamp wrong");

    property p_se_neg;
        @(posedge ref_clk) disable iff (reset)
        (finish && !r_r.lock && !r_r.ana.chan.diff && core_code[11])
        |=> r_r.result == 10'h000;
    endproperty
    a_se_neg: assert property (p_se_neg) else $error("single-ended floor wrong");

    property p_busy_end;
        @(posedge ref_clk) disable iff (reset)
        (conv_busy && core_done) |=> !conv_busy;
    endproperty
    a_busy_end: assert property (p_busy_end) else $error("busy did not end on completion");

endmodule : ars_ctrl

// ===== ars_tb.sv
`timescale 1ns/1ps
`include "ars_consts.svh"
module testbench;
    logic              ref_clk;
    logic              reset;
    logic [7:0]        bus_addr;
    logic [7:0]        bus_wdata;
    logic              bus_we;
    logic              bus_re;
    logic [7:0]        bus_rdata;
    logic              conv_start;
    logic              core_done;
    logic [11:0]       core_code;
    ars_pkg::ars_ana_t ana_ctl;
    logic              conv_busy;
    logic              irq;
    int                n_fail;
    int                check_count;
    logic [7:0]        d;

    ars_ctrl ars_ctrl_inst (.ref_clk(ref_clk), .reset(reset), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_we(bus_we), .bus_re(bus_re), .bus_rdata(bus_rdata), .conv_start(conv_start),
        .core_done(core_done), .core_code(core_code), .ana_ctl(ana_ctl), .conv_busy(conv_busy), .irq(irq));

    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
        check_count++;
        if (g !== e) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge ref_clk);
        bus_addr  <= a;
        bus_wdata <= v;
        bus_we    <= 1'b1;
        @(posedge ref_clk);
        bus_we    <= 1'b0;
        #1;
    endtask : wr

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge ref_clk);
        bus_addr <= a;
        bus_re   <= 1'b1;
        @(posedge ref_clk);
        bus_re   <= 1'b0;
        #1 v = bus_rdata;
    endtask : rd

    task automatic start_c;
        @(posedge ref_clk);
        conv_start <= 1'b1;
        @(posedge ref_clk);
        conv_start <= 1'b0;
        #1;
    endtask : start_c

    task automatic finish_c(input logic [11:0] c);
        @(posedge ref_clk);
        core_done <= 1'b1;
        core_code <= c;
        @(posedge ref_clk);
        core_done <= 1'b0;
        #1;
    endtask : finish_c

    task automatic settle;
        repeat (2) @(posedge ref_clk);
        #1;
    endtask : settle

    // expected bytes come from the 10-bit code and the left-justify bit of sel
    task automatic conv_chk(input logic [7:0] sel, input logic [11:0] c, input logic [9:0] r);
        logic [7:0] lo;
        logic [7:0] hi;
        wr(`ARS_ADDR_INSEL, sel);
        start_c;
        chk("busy", 1, conv_busy);
        chk("start", 1, ana_ctl.start);
        finish_c(c);
        chk("idle", 0, conv_busy);
        rd(`ARS_ADDR_RES_LOW, lo);
        rd(`ARS_ADDR_RES_HIGH, hi);
        if (sel[5]) begin
            chk("low", {r[1:0], 6'h00}, lo);
            chk("high", r[9:2], hi);
        end else begin
            chk("low", r[7:0], lo);
            chk("high", {6'h00, r[9:8]}, hi);
        end
    endtask : conv_chk

    task automatic t_reset_off;
        #1 chk("valid", 1, ana_ctl.chan.valid);
        chk("rdata", 8'h00, bus_rdata);
        chk("irq", 0, irq);
        rd(`ARS_ADDR_INSEL, d);
        chk("insel", 8'h00, d);
        rd(8'h55, d);
        chk("unmapped", 8'h00, d);
        start_c;
        chk("busy off", 0, conv_busy);
        chk("start off", 0, ana_ctl.start);
        wr(`ARS_ADDR_CTRL_A, 8'h80);
        chk("enable", 1, ana_ctl.enable);
    endtask : t_reset_off

    task automatic t_decode;
        for (int i = 0; i < 32; i++) begin
            wr(`ARS_ADDR_INSEL, {i[1:0], 1'b0, i[4:0]});
            settle;
            chk("ref", i[1:0], ana_ctl.ref_sel);
            chk("int ref", i[1:0] == 2'h3, ana_ctl.ref_int_on);
            chk("valid", i[4] | (i < 8), ana_ctl.chan.valid);
            chk("diff", i[4] && (i < 30), ana_ctl.chan.diff);
            chk("bandgap", i == 30, ana_ctl.chan.bandgap);
            chk("ground", i == 31, ana_ctl.chan.ground);
            if (i < 8 || (i >= 16 && i < 30)) chk("pos", i[2:0], ana_ctl.chan.pos);
            if (i >= 16 && i < 30) chk("neg", i[3] ? 3'h2 : 3'h1, ana_ctl.chan.neg);
        end
    endtask : t_decode

    task automatic t_conv;
        conv_chk(8'hFB, 12'hFA3, 10'h3A3);
        rd(`ARS_ADDR_CTRL_A, d);
        chk("ctrl done", 8'h90, d);
        wr(`ARS_ADDR_CTRL_A, 8'h90);
        rd(`ARS_ADDR_CTRL_A, d);
        chk("ctrl done clear", 8'h80, d);
        wr(`ARS_ADDR_INSEL, 8'hDB);
        rd(`ARS_ADDR_RES_LOW, d);
        chk("low right", 8'hA3, d);
        rd(`ARS_ADDR_RES_HIGH, d);
        chk("high right", 8'h03, d);
        conv_chk(8'h47, 12'h500, 10'h3FF);
        conv_chk(8'h67, 12'hFF0, 10'h000);
        conv_chk(8'hD0, 12'hD00, 10'h200);
        conv_chk(8'hD7, 12'h258, 10'h1FF);
        conv_chk(8'h50, 12'h0AB, 10'h0AB);
    endtask : t_conv

    // settings written mid-conversion stay frozen; left-justify does not
    task automatic t_hold;
        wr(`ARS_ADDR_INSEL, 8'hDB);
        start_c;
        wr(`ARS_ADDR_INSEL, 8'h67);
        settle;
        chk("held ref", 2'h3, ana_ctl.ref_sel);
        chk("held pos", 3'h3, ana_ctl.chan.pos);
        chk("held diff", 1, ana_ctl.chan.diff);
        rd(`ARS_ADDR_RES_HIGH, d);
        chk("left now", 8'h2A, d);
        finish_c(12'h031);
        settle;
        chk("new ref", 2'h1, ana_ctl.ref_sel);
        chk("new pos", 3'h7, ana_ctl.chan.pos);
        chk("new diff", 0, ana_ctl.chan.diff);
        rd(`ARS_ADDR_RES_LOW, d);
        chk("low", 8'h40, d);
        rd(`ARS_ADDR_RES_HIGH, d);
        chk("high", 8'h0C, d);
    endtask : t_hold

    task automatic t_lock;
        rd(`ARS_ADDR_RES_LOW, d);
        wr(`ARS_ADDR_STATUS, 8'h07);
        start_c;
        finish_c(12'h111);
        rd(`ARS_ADDR_STATUS, d);
        chk("lost", 8'h05, d);
        rd(`ARS_ADDR_RES_HIGH, d);
        chk("locked high", 8'h0C, d);
        conv_chk(8'h47, 12'h111, 10'h111);
    endtask : t_lock

    task automatic t_abort;
        wr(`ARS_ADDR_STATUS, 8'h07);
        start_c;
        wr(`ARS_ADDR_CTRL_A, 8'h00);
        chk("abort pulse", 1, ana_ctl.abort);
        settle;
        chk("abort busy", 0, conv_busy);
        chk("abort en", 0, ana_ctl.enable);
        finish_c(12'h222);
        rd(`ARS_ADDR_STATUS, d);
        chk("abort status", 8'h02, d);
        // high byte read releases the lock taken by the low byte read
        rd(`ARS_ADDR_RES_LOW, d);
        chk("no result", 8'h11, d);
        rd(`ARS_ADDR_RES_HIGH, d);
        chk("no result high", 8'h01, d);
    endtask : t_abort

    task automatic t_irq;
        wr(`ARS_ADDR_CTRL_A, 8'h80);
        wr(`ARS_ADDR_STATUS, 8'h07);
        wr(`ARS_ADDR_MASK, 8'h01);
        chk("irq idle", 0, irq);
        start_c;
        finish_c(12'h005);
        rd(`ARS_ADDR_STATUS, d);
        chk("status set", 8'h01, d);
        chk("irq set", 1, irq);
        wr(`ARS_ADDR_STATUS, 8'h01);
        rd(`ARS_ADDR_MASK, d);
        chk("mask", 8'h01, d);
        chk("irq clear", 0, irq);
        wr(`ARS_ADDR_MASK, 8'h00);
        start_c;
        finish_c(12'h005);
        rd(`ARS_ADDR_STATUS, d);
        chk("status", 8'h01, d);
        chk("irq masked", 0, irq);
    endtask : t_irq

    task automatic complete_run;
        if (n_fail == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : complete_run

    // hang guard, far beyond the longest sequence
    initial begin
        #1000000;
        n_fail++;
        complete_run;
    end

    initial begin
        n_fail      = 0;
        check_count = 0;
        reset       = 1'b1;
        bus_addr    = 8'h00;
        bus_wdata   = 8'h00;
        bus_we      = 1'b0;
        bus_re      = 1'b0;
        conv_start  = 1'b0;
        core_done   = 1'b0;
        core_code   = 12'h000;
        repeat (6) @(posedge ref_clk);
        reset <= 1'b0;
        t_reset_off;
        t_decode;
        t_conv;
        t_hold;
        t_lock;
        t_abort;
        t_irq;
        complete_run;
    end
endmodule : testbench
